//--- uart_ms_pkg.sv
package uart_ms_pkg;
	// register byte addresses on the mcu bus
	localparam logic [15:0] ADDR_MODEM_LINE_STATE = 16'hffa6;
	localparam logic [15:0] ADDR_BAUD_DIVISOR_LOW = 16'hffa7;
	localparam logic [15:0] ADDR_BAUD_DIVISOR_HIGH = 16'hffa8;
	localparam logic [15:0] ADDR_RESUME_CHAR = 16'hffa9;
	localparam logic [15:0] ADDR_PAUSE_CHAR = 16'hffaa;
	localparam logic [15:0] ADDR_UART_IRQ_ENABLE = 16'hffab;
	// reset values
	localparam logic [7:0] DIV_LOW_RST = 8'h08;
	localparam logic [7:0] DIV_HIGH_RST = 8'h00;
	localparam logic [7:0] RESUME_CHAR_RST = 8'h00;
	localparam logic [7:0] PAUSE_CHAR_RST = 8'h00;
	localparam logic [2:0] IRQ_ENABLE_RST = 3'h0;
	// modem_line_state flag positions
	localparam int MSR_CTS_CHG = 0;
	localparam int MSR_DSR_CHG = 1;
	localparam int MSR_RING_TRAIL = 2;
	localparam int MSR_CD_CHG = 3;
	// uart_irq_enable bit positions
	localparam int MASK_MODEM = 0;
	localparam int MASK_STATUS = 1;
	localparam int MASK_DATA = 2;
	// modem_control_reg bit positions
	localparam int MCR_LOOP = 2;
	localparam int MCR_DTR = 4;
	localparam int MCR_RTS = 5;
	localparam int MCR_LRI = 6;
	localparam int MCR_LCD = 7;
	// baud reference: master clock over 6.5, made from core_clk by a fraction
	localparam longint MASTER_CLK_HZ = 96_000_000;
	localparam longint REF_DIV_X2 = 13;
	localparam longint CORE_CLK_HZ = 20_000_000;
	localparam logic [31:0] REF_ACC_MOD = 32'(CORE_CLK_HZ * REF_DIV_X2);
	localparam logic [31:0] REF_ACC_STEP = 32'(MASTER_CLK_HZ * 2);
	localparam logic [3:0] OVERSAMPLE_LAST = 4'hf;
	localparam logic [3:0] HALF_BIT = 4'h7;
	localparam logic [3:0] FRAME_BITS = 4'ha;
	// receive fifo and marks
	localparam int FIFO_AW = 5;
	localparam logic [5:0] FIFO_DEPTH = 6'h20;
	localparam logic [5:0] HALT_MARK = 6'h0c;
	localparam logic [5:0] RESUME_MARK = 6'h04;
	// buffer area sizes
	localparam int BUF_AREA_BYTES = 512;
	localparam int BUF_HALF_BYTES = 64;
	// flow_control_reg fields
	typedef struct packed {
		logic rs485;
		logic dtr_flow;
		logic rts_auto;
		logic sw_rx;
		logic dsr_flow;
		logic cts_auto;
		logic xon_any;
		logic sw_tx;
	} flow_cfg_s;
	// modem lines as active-high levels
	typedef struct packed {
		logic cd;
		logic ri;
		logic dsr;
		logic cts;
	} modem_s;
endpackage

//--- uart_rx_store.sv
`timescale 1ns/10ps
`default_nettype none
// receive byte store with registered read data
module uart_rx_store
	import uart_ms_pkg::*;
(
	// clock
	input wire logic core_clk,
	// write side
	input wire logic wr_en,
	input wire logic [FIFO_AW-1:0] waddr,
	input wire logic [7:0] wdata,
	// read side
	input wire logic [FIFO_AW-1:0] raddr,
	output logic [7:0] rdata_q
);
	logic [7:0] mem [0:(1<<FIFO_AW)-1]; // byte cells

	// write port
	always_ff @(posedge core_clk) begin
		if (wr_en) begin
			mem[waddr] <= wdata;
		end
	end

	// read port, one cycle latency
	always_ff @(posedge core_clk) begin
		rdata_q <= mem[raddr];
	end
endmodule // uart_rx_store
`default_nettype wire

//--- uart_modem_flow.sv
`timescale 1ns/10ps
`default_nettype none
//Contract
// - cts, dsr, cd changes set sticky flags
// - flag clears only on written one
// - ring trailing edge (ri_n rising) sets bit two
// - loopback: bits 4-7 show control bits
// - bits 5,6 read one when pin low
// - 16-bit divisor, resets 08h/00h
// - reference is 96 MHz over 6.5
// - divisor gives sixteen-times oversample tick
// - resume char matched, sent, gated interrupt
// - pause char match halts dma, sent
// - mask gates modem, status, data interrupts
// - 512-byte area, 64-byte x/y halves
// - 32-byte fifo, halt 12, resume 4
// - auto rts follows halt/resume marks
// - software rx flow sends pause/resume
// - auto cts suspends transmit dma
// - pause char stops, resume restarts tx
// - paused: swap only y empty, x full
// - flow controls enabled independently
// - loopback routes tx to rx
module uart_modem_flow
	import uart_ms_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// mcu register port
	input wire logic [15:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata_q,
	// control registers kept elsewhere
	input wire logic [7:0] modem_control_reg,
	input wire flow_cfg_s flow_control_reg,
	// line pins
	input wire logic sin,
	input wire logic cts_n,
	input wire logic dsr_n,
	input wire logic ri_n,
	input wire logic dcd_n,
	output logic sout,
	output logic rts_n,
	output logic dtr_n,
	// transmit dma
	input wire logic tx_dma_valid,
	input wire logic [7:0] tx_dma_data,
	output logic tx_dma_ready,
	// receive dma
	output logic rx_dma_valid,
	output logic [7:0] rx_dma_data,
	input wire logic rx_dma_ready,
	// x/y double buffer
	input wire logic swap_req,
	input wire logic y_empty,
	input wire logic x_full,
	output logic swap_ok,
	output logic dma_half_q,
	// interrupts
	output logic modem_irq_q,
	output logic status_irq_q,
	output logic data_irq_q
);
	typedef enum {TX_IDLE, TX_BUSY} tx_state_e;
	typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_e;

	logic [4:0] s1_q, s2_q, s3_q, st_q; // pin synchronisers, stable level
	modem_s act; // effective modem lines, active high
	modem_s act_prev_q; // last cycle's lines
	logic [3:0] flags_q; // sticky change flags
	logic [7:0] div_low_q, div_high_q, resume_q, pause_q;
	logic [2:0] irq_en_q; // interrupt mask
	logic msr_wr; // write to modem_line_state
	logic [31:0] ref_acc_q; // fractional accumulator
	logic ref_en; // baud reference pulse
	logic [15:0] div_cnt_q; // divisor counter
	logic os_tick; // sixteen-times tick
	logic loop_on; // loopback selected
	logic tx_line_q; // transmitter serial level
	tx_state_e tx_state_q;
	logic [9:0] tx_sh_q; // frame shifter
	logic [3:0] tx_os_q, tx_bits_q;
	logic pend_pause_q, pend_resume_q; // flow chars waiting
	logic tx_take; // dma byte accepted
	rx_state_e rx_state_q;
	logic [3:0] rx_os_q, rx_bits_q;
	logic [7:0] rx_sh_q;
	logic rx_in; // receiver input line
	logic rx_done; // good byte received
	logic [5:0] cnt_q; // fifo fill
	logic [FIFO_AW-1:0] wp_q, rp_q;
	logic stale_q; // read data not yet refreshed
	logic push, pop;
	logic halt_q; // set at halt mark, cleared at resume mark
	logic tx_paused_q; // paused by received pause char
	logic match_resume, match_pause;

	// pin synchronisers: a level counts once stages two and three agree
	assign loop_on = modem_control_reg[MCR_LOOP];
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			s1_q <= 5'h1f;
			s2_q <= 5'h1f;
			s3_q <= 5'h1f;
			st_q <= 5'h1f;
		end else begin
			s1_q <= {sin, dcd_n, ri_n, dsr_n, cts_n};
			s2_q <= s1_q;
			s3_q <= s2_q;
			for (int i = 0; i < 5; i++) begin
				if (s2_q[i] == s3_q[i]) begin
					st_q[i] <= s3_q[i];
				end
			end
		end
	end

	// effective lines: pins inverted, or control bits in loopback
	always_comb begin
		if (loop_on) begin
			act.cts = modem_control_reg[MCR_DTR];
			act.dsr = modem_control_reg[MCR_RTS];
			act.ri = modem_control_reg[MCR_LRI];
			act.cd = modem_control_reg[MCR_LCD];
		end else begin
			act.cts = ~st_q[0];
			act.dsr = ~st_q[1];
			act.ri = ~st_q[2];
			act.cd = ~st_q[3];
		end
	end

	// change flags: set beats a clearing write
	assign msr_wr = reg_wr && (reg_addr == ADDR_MODEM_LINE_STATE);
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			act_prev_q <= '0;
			flags_q <= 4'h0;
		end else begin
			act_prev_q <= act;
			for (int i = 0; i < 4; i++) begin
				if (msr_wr && reg_wdata[i]) begin
					flags_q[i] <= 1'b0;
				end
			end
			if (act.cts != act_prev_q.cts) begin
				flags_q[MSR_CTS_CHG] <= 1'b1;
			end
			if (act.dsr != act_prev_q.dsr) begin
				flags_q[MSR_DSR_CHG] <= 1'b1;
			end
			if (act_prev_q.ri && !act.ri) begin
				flags_q[MSR_RING_TRAIL] <= 1'b1;
			end
			if (act.cd != act_prev_q.cd) begin
				flags_q[MSR_CD_CHG] <= 1'b1;
			end
		end
	end

	// plain read/write registers
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			div_low_q <= DIV_LOW_RST;
			div_high_q <= DIV_HIGH_RST;
			resume_q <= RESUME_CHAR_RST;
			pause_q <= PAUSE_CHAR_RST;
			irq_en_q <= IRQ_ENABLE_RST;
		end else if (reg_wr) begin
			case (reg_addr)
				ADDR_BAUD_DIVISOR_LOW: div_low_q <= reg_wdata;
				ADDR_BAUD_DIVISOR_HIGH: div_high_q <= reg_wdata;
				ADDR_RESUME_CHAR: resume_q <= reg_wdata;
				ADDR_PAUSE_CHAR: pause_q <= reg_wdata;
				ADDR_UART_IRQ_ENABLE: irq_en_q <= reg_wdata[2:0];
				default: ;
			endcase
		end
	end

	// read data, unmapped addresses read zero
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			reg_rdata_q <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				ADDR_MODEM_LINE_STATE: reg_rdata_q <= {act.cd, act.ri, act.dsr, act.cts, flags_q};
				ADDR_BAUD_DIVISOR_LOW: reg_rdata_q <= div_low_q;
				ADDR_BAUD_DIVISOR_HIGH: reg_rdata_q <= div_high_q;
				ADDR_RESUME_CHAR: reg_rdata_q <= resume_q;
				ADDR_PAUSE_CHAR: reg_rdata_q <= pause_q;
				ADDR_UART_IRQ_ENABLE: reg_rdata_q <= {5'h00, irq_en_q};
				default: reg_rdata_q <= 8'h00;
			endcase
		end
	end

	// fractional divider: reference pulses at 96 MHz / 6.5 average
	assign ref_en = (ref_acc_q + REF_ACC_STEP) >= REF_ACC_MOD;
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			ref_acc_q <= 32'h0000_0000;
		end else if (ref_en) begin
			ref_acc_q <= ref_acc_q + REF_ACC_STEP - REF_ACC_MOD;
		end else begin
			ref_acc_q <= ref_acc_q + REF_ACC_STEP;
		end
	end

	// divisor counter: one oversample tick per divisor reference pulses
	assign os_tick = ref_en && (div_cnt_q <= 16'h0001);
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			div_cnt_q <= 16'h0000;
		end else if (os_tick) begin
			div_cnt_q <= {div_high_q, div_low_q};
		end else if (ref_en) begin
			div_cnt_q <= div_cnt_q - 16'h0001;
		end
	end

	// transmitter: flow chars go before dma data
	assign tx_dma_ready = (tx_state_q == TX_IDLE) && !pend_pause_q && !pend_resume_q
		&& !(flow_control_reg.cts_auto && !act.cts)
		&& !(flow_control_reg.sw_tx && tx_paused_q);
	assign tx_take = tx_dma_ready && tx_dma_valid;
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			tx_state_q <= TX_IDLE;
			tx_sh_q <= 10'h3ff;
			tx_os_q <= 4'h0;
			tx_bits_q <= 4'h0;
		end else begin
			case (tx_state_q)
				TX_IDLE: begin
					tx_os_q <= 4'h0;
					tx_bits_q <= 4'h0;
					if (pend_pause_q) begin
						tx_sh_q <= {1'b1, pause_q, 1'b0};
						tx_state_q <= TX_BUSY;
					end else if (pend_resume_q) begin
						tx_sh_q <= {1'b1, resume_q, 1'b0};
						tx_state_q <= TX_BUSY;
					end else if (tx_take) begin
						tx_sh_q <= {1'b1, tx_dma_data, 1'b0};
						tx_state_q <= TX_BUSY;
					end
				end
				TX_BUSY: begin
					if (os_tick) begin
						tx_os_q <= tx_os_q + 4'h1;
						if (tx_os_q == OVERSAMPLE_LAST) begin
							tx_sh_q <= {1'b1, tx_sh_q[9:1]};
							tx_bits_q <= tx_bits_q + 4'h1;
							if (tx_bits_q == FRAME_BITS - 4'h1) begin
								tx_state_q <= TX_IDLE;
							end
						end
					end
				end
				default: tx_state_q <= TX_IDLE;
			endcase
		end
	end

	// serial line: held high when idle, sout held high in loopback
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			tx_line_q <= 1'b1;
		end else begin
			tx_line_q <= (tx_state_q == TX_BUSY) ? tx_sh_q[0] : 1'b1;
		end
	end
	assign sout = loop_on ? 1'b1 : tx_line_q;
	assign rx_in = loop_on ? tx_line_q : st_q[4];

	// receiver: 8n1, sampled mid-bit on oversample ticks
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			rx_state_q <= RX_IDLE;
			rx_os_q <= 4'h0;
			rx_bits_q <= 4'h0;
			rx_sh_q <= 8'h00;
		end else if (os_tick) begin
			rx_os_q <= rx_os_q + 4'h1;
			case (rx_state_q)
				RX_IDLE: begin
					rx_os_q <= 4'h0;
					if (!rx_in) begin
						rx_state_q <= RX_START;
					end
				end
				RX_START: begin
					if (rx_os_q == HALF_BIT) begin
						rx_os_q <= 4'h0;
						rx_bits_q <= 4'h0;
						rx_state_q <= rx_in ? RX_IDLE : RX_DATA;
					end
				end
				RX_DATA: begin
					if (rx_os_q == OVERSAMPLE_LAST) begin
						rx_sh_q <= {rx_in, rx_sh_q[7:1]};
						rx_bits_q <= rx_bits_q + 4'h1;
						if (rx_bits_q == 4'h7) begin
							rx_state_q <= RX_STOP;
						end
					end
				end
				RX_STOP: begin
					if (rx_os_q == OVERSAMPLE_LAST) begin
						rx_state_q <= RX_IDLE;
					end
				end
				default: rx_state_q <= RX_IDLE;
			endcase
		end
	end
	assign rx_done = os_tick && (rx_state_q == RX_STOP) && (rx_os_q == OVERSAMPLE_LAST) && rx_in;
	assign match_resume = rx_done && (rx_sh_q == resume_q);
	assign match_pause = rx_done && (rx_sh_q == pause_q);

	// receive fifo bookkeeping, bytes beyond full are dropped
	assign push = rx_done && (cnt_q != FIFO_DEPTH);
	assign pop = rx_dma_valid && rx_dma_ready;
	assign rx_dma_valid = (cnt_q != 6'h00) && !stale_q;
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			cnt_q <= 6'h00;
			wp_q <= '0;
			rp_q <= '0;
			stale_q <= 1'b0;
		end else begin
			wp_q <= push ? wp_q + 1'b1 : wp_q;
			rp_q <= pop ? rp_q + 1'b1 : rp_q;
			cnt_q <= cnt_q + {5'h00, push} - {5'h00, pop};
			stale_q <= pop || (push && cnt_q == 6'h00);
		end
	end
	uart_rx_store u_store (
		.core_clk(core_clk),
		.wr_en(push),
		.waddr(wp_q),
		.wdata(rx_sh_q),
		.raddr(rp_q),
		.rdata_q(rx_dma_data)
	);

	// halt/resume marks and the flow chars they request
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			halt_q <= 1'b0;
			pend_pause_q <= 1'b0;
			pend_resume_q <= 1'b0;
		end else begin
			if (!halt_q && cnt_q >= HALT_MARK) begin
				halt_q <= 1'b1;
				pend_pause_q <= flow_control_reg.sw_rx;
			end else if (halt_q && cnt_q <= RESUME_MARK) begin
				halt_q <= 1'b0;
				pend_resume_q <= flow_control_reg.sw_rx;
			end else if (tx_state_q == TX_IDLE) begin
				if (pend_pause_q) begin
					pend_pause_q <= 1'b0;
				end else begin
					pend_resume_q <= 1'b0;
				end
			end
		end
	end
	assign rts_n = flow_control_reg.rts_auto ? halt_q : !modem_control_reg[MCR_RTS];
	assign dtr_n = !modem_control_reg[MCR_DTR];

	// transmit pause state from received chars
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			tx_paused_q <= 1'b0;
		end else if (!flow_control_reg.sw_tx) begin
			tx_paused_q <= 1'b0;
		end else if (match_pause) begin
			tx_paused_q <= 1'b1;
		end else if (match_resume) begin
			tx_paused_q <= 1'b0;
		end
	end

	// x/y half select, swaps held off while paused unless y empty and x full
	assign swap_ok = !tx_paused_q || (y_empty && x_full);
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			dma_half_q <= 1'b0;
		end else if (swap_req && swap_ok) begin
			dma_half_q <= !dma_half_q;
		end
	end

	// interrupt lines gated by the mask
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			modem_irq_q <= 1'b0;
			status_irq_q <= 1'b0;
			data_irq_q <= 1'b0;
		end else begin
			modem_irq_q <= irq_en_q[MASK_MODEM] && (flags_q != 4'h0);
			status_irq_q <= irq_en_q[MASK_STATUS] && (match_resume || match_pause);
			data_irq_q <= irq_en_q[MASK_DATA] && (rx_dma_valid || tx_state_q == TX_IDLE);
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	AST_CTS_FLAG: assert property (act.cts != act_prev_q.cts |=> flags_q[MSR_CTS_CHG])
		else $error("cts change not flagged");
	AST_W1_CLEARS: assert property (msr_wr && reg_wdata[MSR_CD_CHG] && act.cd == act_prev_q.cd
		|=> !flags_q[MSR_CD_CHG])
		else $error("cd flag not cleared by write of one");
	AST_W0_KEEPS: assert property (msr_wr && !reg_wdata[MSR_DSR_CHG] && flags_q[MSR_DSR_CHG]
		|=> flags_q[MSR_DSR_CHG])
		else $error("dsr flag lost on write of zero");
	AST_RING_TRAIL: assert property (act_prev_q.ri && !act.ri |=> flags_q[MSR_RING_TRAIL])
		else $error("ring trailing edge not flagged");
	AST_LOOP_READ: assert property (loop_on && reg_rd && reg_addr == ADDR_MODEM_LINE_STATE
		|=> reg_rdata_q[7:4] == $past(modem_control_reg[7:4]))
		else $error("loopback status bits wrong");
	AST_DIV_RESET: assert property ($past(sys_rst) |-> {div_high_q, div_low_q} == 16'h0008)
		else $error("divisor reset value wrong");
	// auto mode must still be on when the pin is looked at
	AST_RTS_HALT: assert property (flow_control_reg.rts_auto && cnt_q >= HALT_MARK
		##1 flow_control_reg.rts_auto |-> rts_n)
		else $error("rts not raised at halt mark");
	AST_RTS_RESUME: assert property (flow_control_reg.rts_auto && cnt_q <= RESUME_MARK
		##1 flow_control_reg.rts_auto |-> !rts_n)
		else $error("rts not lowered at resume mark");
	AST_CTS_GATE: assert property (flow_control_reg.cts_auto && !act.cts |-> !tx_dma_ready)
		else $error("dma taken while cts inactive");
	AST_PAUSE_HOLD: assert property (flow_control_reg.sw_tx && match_pause && !match_resume
		|=> tx_paused_q && !tx_dma_ready)
		else $error("pause char did not pause");
	AST_SWAP_HOLD: assert property (tx_paused_q && !(y_empty && x_full) && swap_req
		|=> $stable(dma_half_q))
		else $error("buffers swapped while paused");
	AST_LOOP_SOUT: assert property (loop_on |-> sout)
		else $error("sout not high in loopback");
	AST_MASK_OFF: assert property (!irq_en_q[MASK_MODEM] |=> !modem_irq_q)
		else $error("modem interrupt not masked");
	// only from an idle transmitter with nothing else queued ahead of the pause char
	AST_SEND_PAUSE: assert property (flow_control_reg.sw_rx && !halt_q && cnt_q >= HALT_MARK
		&& tx_state_q == TX_IDLE && !pend_pause_q && !pend_resume_q && !tx_take
		|=> pend_pause_q ##1 tx_state_q == TX_BUSY && tx_sh_q[8:1] == pause_q)
		else $error("pause char not sent at halt mark");

	COV_RX_BYTE: cover property (push);
	COV_HALT: cover property (halt_q && pend_pause_q);
	COV_PAUSED: cover property (tx_paused_q && swap_req);
	COV_RING: cover property (flags_q[MSR_RING_TRAIL]);
endmodule // uart_modem_flow
`default_nettype wire

//--- uart_line_partner.sv
`timescale 1ns/10ps
`default_nettype none
// behavioural modem at the far end of the serial line
module uart_line_partner #(
	parameter int BIT_NS = 1083 // one bit at divisor 1: sixteen reference ticks
) (
	// serial data
	input wire logic sout,
	output var logic sin,
	// modem lines, active low
	output var logic cts_n,
	output var logic dsr_n,
	output var logic ri_n,
	output var logic dcd_n
);
	// idle line high, all modem lines inactive
	initial begin
		sin = 1'b1;
		{dcd_n, ri_n, dsr_n, cts_n} = 4'hf;
	end
	// drive the four modem lines, order cd ri dsr cts
	task automatic set_pins(input logic [3:0] p);
		{dcd_n, ri_n, dsr_n, cts_n} = p;
	endtask
	// send one 8n1 frame, lsb first, then idle high
	task automatic send_byte(input logic [7:0] b);
		sin = 1'b0;
		#(BIT_NS);
		for (int i = 0; i < 8; i++) begin
			sin = b[i];
			#(BIT_NS);
		end
		sin = 1'b1;
		#(BIT_NS);
	endtask
	// receive one frame, sampling each bit in its middle
	task automatic get_byte(output logic [7:0] b);
		@(negedge sout);
		#(BIT_NS + BIT_NS / 2);
		for (int i = 0; i < 8; i++) begin
			b[i] = sout;
			#(BIT_NS);
		end
	endtask
endmodule // uart_line_partner
`default_nettype wire

//--- uart_modem_flow_tb.sv
`timescale 1ns/10ps
`default_nettype none
module uart_modem_flow_tb import uart_ms_pkg::*; ();
	// design stimulus and observation
	logic core_clk, sys_rst, reg_wr, reg_rd;
	logic [15:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata_q, modem_control_reg, tx_dma_data, rx_dma_data;
	flow_cfg_s flow_control_reg;
	wire logic sin, cts_n, dsr_n, ri_n, dcd_n;
	logic sout, rts_n, dtr_n, tx_dma_valid, tx_dma_ready, rx_dma_valid, rx_dma_ready;
	logic swap_req, y_empty, x_full, swap_ok, dma_half_q, modem_irq_q, status_irq_q, data_irq_q;
	// bench bookkeeping
	int errors, checks_done, k;
	logic stat_seen;
	logic [7:0] d, got, flag, lvl;
	logic [7:0] rst_tab [6] = '{8'h00, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00};

	uart_modem_flow dut (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
		.modem_control_reg(modem_control_reg), .flow_control_reg(flow_control_reg),
		.sin(sin), .cts_n(cts_n), .dsr_n(dsr_n), .ri_n(ri_n), .dcd_n(dcd_n), .sout(sout),
		.rts_n(rts_n), .dtr_n(dtr_n), .tx_dma_valid(tx_dma_valid), .tx_dma_data(tx_dma_data),
		.tx_dma_ready(tx_dma_ready), .rx_dma_valid(rx_dma_valid), .rx_dma_data(rx_dma_data),
		.rx_dma_ready(rx_dma_ready), .swap_req(swap_req), .y_empty(y_empty), .x_full(x_full),
		.swap_ok(swap_ok), .dma_half_q(dma_half_q), .modem_irq_q(modem_irq_q),
		.status_irq_q(status_irq_q), .data_irq_q(data_irq_q));
	uart_line_partner line_end (.sout(sout), .sin(sin), .cts_n(cts_n), .dsr_n(dsr_n),
		.ri_n(ri_n), .dcd_n(dcd_n));

	// 20 mhz core clock
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	// catch the one-cycle status pulse
	always @(posedge core_clk) begin
		if (status_irq_q === 1'b1) stat_seen <= 1'b1;
	end
	// step to just after a rising edge
	task automatic tick(input int n = 1);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	// compare and count
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// one-cycle register write, then an idle cycle before the next strobe
	task automatic wr(input logic [15:0] a, input logic [7:0] v);
		reg_addr = a;
		reg_wdata = v;
		reg_wr = 1'b1;
		tick();
		reg_wr = 1'b0;
		tick();
	endtask
	// register read, data registered on the taking edge, then an idle cycle
	task automatic rd(input logic [15:0] a, output logic [7:0] v);
		reg_addr = a;
		reg_rd = 1'b1;
		tick();
		reg_rd = 1'b0;
		v = reg_rdata_q;
		tick();
	endtask
	// drive the control registers held outside the block
	task automatic set_ctl(input logic [7:0] m, input flow_cfg_s f);
		modem_control_reg = m;
		flow_control_reg = f;
	endtask
	// drive the buffer manager's side of the x/y halves
	task automatic set_buf(input logic req, input logic ye, input logic xf);
		swap_req = req;
		y_empty = ye;
		x_full = xf;
	endtask
	task automatic expect_reg(input logic [15:0] a, input logic [7:0] exp);
		logic [7:0] v;
		rd(a, v);
		chk(v, exp);
	endtask
	// reset held for eight cycles with the modem lines idle
	task automatic do_reset;
		line_end.set_pins(4'hf);
		sys_rst = 1'b1;
		tick(8);
		sys_rst = 1'b0;
		stat_seen = 1'b0;
	endtask
	// take one byte from the receive fifo, leaving a spare cycle after
	task automatic pop(input logic [7:0] exp);
		int n;
		n = 0;
		while (rx_dma_valid !== 1'b1 && n < 20) begin
			tick();
			n++;
		end
		chk(rx_dma_data, exp);
		rx_dma_ready = 1'b1;
		tick();
		rx_dma_ready = 1'b0;
		tick();
	endtask
	// offer one byte to the transmitter once it is ready
	task automatic send_tx(input logic [7:0] v);
		int n;
		n = 0;
		while (tx_dma_ready !== 1'b1 && n < 400) begin
			tick();
			n++;
		end
		tx_dma_data = v;
		tx_dma_valid = 1'b1;
		tick();
		tx_dma_valid = 1'b0;
	endtask
	task automatic give_verdict;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// cut a hang short
	initial begin
		#3_000_000;
		errors++;
		give_verdict();
	end

	initial begin
		errors = 0;
		checks_done = 0;
		stat_seen = 1'b0;
		sys_rst = 1'b1;
		{reg_wr, reg_rd, tx_dma_valid, rx_dma_ready} = 4'h0;
		set_buf(1'b0, 1'b0, 1'b0);
		reg_addr = 16'h0000;
		reg_wdata = 8'h00;
		tx_dma_data = 8'h00;
		set_ctl(8'h00, flow_cfg_s'(8'h00));
		do_reset();
		// register table reset values, unmapped and read-only places
		for (k = 0; k < 6; k++) expect_reg(ADDR_MODEM_LINE_STATE + 16'(k), rst_tab[k]);
		expect_reg(16'hffac, 8'h00);
		expect_reg(16'hffa5, 8'h00);
		for (k = 1; k < 5; k++) begin
			wr(ADDR_MODEM_LINE_STATE + 16'(k), 8'h5a ^ 8'(k));
			expect_reg(ADDR_MODEM_LINE_STATE + 16'(k), 8'h5a ^ 8'(k));
		end
		wr(ADDR_UART_IRQ_ENABLE, 8'hff);
		expect_reg(ADDR_UART_IRQ_ENABLE, 8'h07);
		chk(8'(data_irq_q), 8'h01);
		wr(ADDR_MODEM_LINE_STATE, 8'hff);
		expect_reg(ADDR_MODEM_LINE_STATE, 8'h00);
		// cts, dsr and cd: both edges flag, only a written one clears
		for (k = 0; k < 3; k++) begin
			flag = 8'h01 << ((k == 2) ? 3 : k);
			lvl = flag << 4;
			line_end.set_pins(~flag[3:0]);
			tick(8);
			expect_reg(ADDR_MODEM_LINE_STATE, lvl | flag);
			chk(8'(modem_irq_q), 8'h01);
			wr(ADDR_MODEM_LINE_STATE, 8'h00);
			expect_reg(ADDR_MODEM_LINE_STATE, lvl | flag);
			wr(ADDR_MODEM_LINE_STATE, flag);
			expect_reg(ADDR_MODEM_LINE_STATE, lvl);
			chk(8'(modem_irq_q), 8'h00);
			line_end.set_pins(4'hf);
			tick(8);
			expect_reg(ADDR_MODEM_LINE_STATE, flag);
			wr(ADDR_MODEM_LINE_STATE, flag);
		end
		// ring: only the return to high is flagged
		line_end.set_pins(4'hb);
		tick(8);
		expect_reg(ADDR_MODEM_LINE_STATE, 8'h40);
		line_end.set_pins(4'hf);
		tick(8);
		expect_reg(ADDR_MODEM_LINE_STATE, 8'h04);
		wr(ADDR_MODEM_LINE_STATE, 8'h04);
		expect_reg(ADDR_MODEM_LINE_STATE, 8'h00);
		// loop-back mirrors the control bits and parks the line high
		set_ctl(8'hf4, flow_cfg_s'(8'h00));
		tick(8);
		chk(8'(dtr_n), 8'h00);
		rd(ADDR_MODEM_LINE_STATE, d);
		chk(d >> 4, 8'h0f);
		set_ctl(8'h54, flow_cfg_s'(8'h00));
		tick(8);
		rd(ADDR_MODEM_LINE_STATE, d);
		chk(d >> 4, 8'h05);
		chk(8'(sout), 8'h01);
		// receive: auto rts and software receive flow together
		do_reset();
		set_ctl(8'h20, flow_cfg_s'(8'h00));
		wr(ADDR_BAUD_DIVISOR_LOW, 8'h01);
		wr(ADDR_RESUME_CHAR, 8'h11);
		wr(ADDR_PAUSE_CHAR, 8'h13);
		set_ctl(8'h20, flow_cfg_s'(8'h30));
		tick(20);
		fork
			for (int i = 0; i < 12; i++) begin
				line_end.send_byte(8'h40 + 8'(i));
				tick(4);
				chk(8'(rts_n), (i == 11) ? 8'h01 : 8'h00);
			end
			line_end.get_byte(got);
		join
		chk(got, 8'h13);
		fork
			for (int i = 0; i < 8; i++) begin
				pop(8'h40 + 8'(i));
				tick(3);
				chk(8'(rts_n), (i == 7) ? 8'h00 : 8'h01);
			end
			line_end.get_byte(got);
		join
		chk(got, 8'h11);
		// transmit paused and restarted by received characters
		do_reset();
		set_ctl(8'h00, flow_cfg_s'(8'h01));
		wr(ADDR_BAUD_DIVISOR_LOW, 8'h01);
		wr(ADDR_RESUME_CHAR, 8'h11);
		wr(ADDR_PAUSE_CHAR, 8'h13);
		wr(ADDR_UART_IRQ_ENABLE, 8'h02);
		tick(20);
		line_end.send_byte(8'h13);
		tick(4);
		chk(8'(tx_dma_ready), 8'h00);
		chk(8'(stat_seen), 8'h01);
		chk(8'(data_irq_q), 8'h00);
		// while paused the halves swap only with y empty and x full
		set_buf(1'b1, 1'b0, 1'b1);
		tick();
		chk(8'(swap_ok), 8'h00);
		chk(8'(dma_half_q), 8'h00);
		set_buf(1'b1, 1'b1, 1'b1);
		#1;
		chk(8'(swap_ok), 8'h01);
		tick();
		set_buf(1'b0, 1'b1, 1'b1);
		chk(8'(dma_half_q), 8'h01);
		stat_seen = 1'b0;
		line_end.send_byte(8'h11);
		tick(4);
		chk(8'(tx_dma_ready), 8'h01);
		chk(8'(stat_seen), 8'h01);
		// one byte out, lsb first at the programmed rate
		fork
			send_tx(8'ha5);
			line_end.get_byte(got);
		join
		chk(got, 8'ha5);
		// auto cts holds transmit dma while the line is high
		set_ctl(8'h00, flow_cfg_s'(8'h05));
		tick(60);
		chk(8'(tx_dma_ready), 8'h00);
		line_end.set_pins(4'he);
		tick(8);
		chk(8'(tx_dma_ready), 8'h01);
		line_end.set_pins(4'hf);
		tick(8);
		chk(8'(tx_dma_ready), 8'h00);
		give_verdict();
	end
endmodule // uart_modem_flow_tb
`default_nettype wire
